// ==== verilog/mio_ports.sv ====
// multiplexed open-drain i/o port block with ahb-lite registers
`timescale 1ns/1ps
`include "mio_regs.svh"
module mio_ports
	import mio_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// single-bit port pins
	input wire logic [3:0] bit_port_pins_in,
	output logic [3:0] bit_port_pins_out,
	output logic [3:0] bit_port_pins_oe,
	// first nibble port
	input wire logic [3:0] nibble_port_first_in,
	output logic [3:0] nibble_port_first_out,
	output logic [3:0] nibble_port_first_oe,
	// second nibble port
	input wire logic [3:0] nibble_port_second_in,
	output logic [3:0] nibble_port_second_out,
	output logic [3:0] nibble_port_second_oe,
	// pair port
	input wire logic [1:0] pair_port_in,
	output logic [1:0] pair_port_out,
	output logic [1:0] pair_port_oe,
	// pull-up controls to the pads, same layout as the key-on register
	output logic [11:0] pull_up_en,
	// reset pin
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic wdt_reset_req,
	input wire logic por_reset_req,
	// skip test from the cpu
	input wire logic [1:0] bit_test_sel,
	output logic bit_test_skip,
	// timers, interrupt and converter side
	input wire logic t1_underflow,
	input wire logic t2_underflow,
	output logic timer_count_in,
	output logic ext_int_level,
	output logic [1:0] analog_inputs,
	// power state and events
	input wire logic ram_backup,
	output logic wakeup_req,
	output logic irq
);
	logic [3:0] bit_latch_q;
	logic [3:0] nib0_latch_q;
	logic [3:0] nib1_latch_q;
	logic [1:0] pair_latch_q;
	logic [11:0] pullup_q;
	logic [11:0] keyon_q;
	mio_tp_mode_t tp_mode_q;
	logic int_en_q;
	logic tp_toggle_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_en_q;
	logic int_prev_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic bit_skip_q;
	logic tcount_q;
	logic ext_int_q;
	logic [1:0] analog_q;
	logic addr_ok;
	logic int_fall;
	logic [11:0] pin_level;
	mio_key_if key ();

	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = wr_pend_q && (wr_addr_q == ofs);
	endfunction : wr_hit

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		unique case (a)
			`MIO_OFS_BIT_LATCH: reg_read = {28'h0000000, bit_latch_q};
			`MIO_OFS_NIB0_LATCH: reg_read = {28'h0000000, nib0_latch_q};
			`MIO_OFS_NIB1_LATCH: reg_read = {28'h0000000, nib1_latch_q};
			`MIO_OFS_PAIR_LATCH: reg_read = {30'h0, pair_latch_q};
			`MIO_OFS_PIN_LEVEL: reg_read = {18'h0, pin_level[11:10], bit_port_pins_in[1:0],
				pin_level[9:0]};
			`MIO_OFS_PULLUP: reg_read = {20'h00000, pullup_q};
			`MIO_OFS_KEYON: reg_read = {20'h00000, keyon_q};
			`MIO_OFS_CTRL: reg_read = {29'h0, int_en_q, tp_mode_q};
			`MIO_OFS_IRQ_STAT: reg_read = {30'h0, irq_stat_q};
			`MIO_OFS_IRQ_EN: reg_read = {30'h0, irq_en_q};
			default: reg_read = 32'h00000000;
		endcase
	endfunction : reg_read

	// pin level vector in wakeup layout: nib0, nib1, pair, single-bit 2 and 3
	assign pin_level = {bit_port_pins_in[3:2], pair_port_in, nibble_port_second_in,
		nibble_port_first_in};
	assign addr_ok = hsel && htrans[1] && hready;

	// zero wait state slave; every answer is okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_addr_q <= {haddr[7:2], 2'b00};
			end
		end
	end

	// read data is captured in the address phase so it comes from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (addr_ok && !hwrite) begin
			hrdata_q <= reg_read({haddr[7:2], 2'b00});
		end
	end
	assign hrdata = hrdata_q;

	// output latches; reset releases every pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_latch_q <= `MIO_RST_LATCH4;
			nib0_latch_q <= `MIO_RST_LATCH4;
			nib1_latch_q <= `MIO_RST_LATCH4;
			pair_latch_q <= `MIO_RST_LATCH2;
		end else begin
			if (wr_hit(`MIO_OFS_BIT_LATCH)) begin
				bit_latch_q <= hwdata[3:0];
			end
			if (wr_hit(`MIO_OFS_NIB0_LATCH)) begin
				nib0_latch_q <= hwdata[3:0];
			end
			if (wr_hit(`MIO_OFS_NIB1_LATCH)) begin
				nib1_latch_q <= hwdata[3:0];
			end
			if (wr_hit(`MIO_OFS_PAIR_LATCH)) begin
				pair_latch_q <= hwdata[1:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pullup_q <= `MIO_RST_SEL12;
			keyon_q <= `MIO_RST_SEL12;
			tp_mode_q <= MIO_TP_INPUT;
			int_en_q <= 1'b0;
			irq_en_q <= 2'b00;
		end else begin
			if (wr_hit(`MIO_OFS_PULLUP)) begin
				pullup_q <= hwdata[11:0];
			end
			if (wr_hit(`MIO_OFS_KEYON)) begin
				keyon_q <= hwdata[11:0];
			end
			if (wr_hit(`MIO_OFS_CTRL)) begin
				int_en_q <= hwdata[`MIO_CTRL_INTEN_BIT];
				// code 3 is not a mode; it falls back to plain input
				unique case (hwdata[`MIO_CTRL_MODE_LSB +: 2])
					2'h1: tp_mode_q <= MIO_TP_T1_OUT;
					2'h2: tp_mode_q <= MIO_TP_T2_OUT;
					default: tp_mode_q <= MIO_TP_INPUT;
				endcase
			end
			if (wr_hit(`MIO_OFS_IRQ_EN)) begin
				irq_en_q <= hwdata[1:0];
			end
		end
	end
	assign pull_up_en = pullup_q;

	// underflow divided by two: one toggle per selected underflow pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tp_toggle_q <= 1'b1;
		end else if (tp_mode_q == MIO_TP_INPUT) begin
			tp_toggle_q <= 1'b1;
		end else if ((tp_mode_q == MIO_TP_T1_OUT) ? t1_underflow : t2_underflow) begin
			tp_toggle_q <= ~tp_toggle_q;
		end
	end

	// open-drain: out is always low, enable only where a zero must be driven
	assign bit_port_pins_out = 4'h0;
	assign nibble_port_first_out = 4'h0;
	assign nibble_port_second_out = 4'h0;
	assign pair_port_out = 2'h0;
	assign reset_pin_out = 1'b0;
	assign bit_port_pins_oe = ~bit_latch_q;
	assign nibble_port_first_oe = ~nib0_latch_q;
	assign nibble_port_second_oe = {~nib1_latch_q[3],
		~nib1_latch_q[`MIO_TP_BIT] | ~tp_toggle_q, ~nib1_latch_q[1:0]};
	assign pair_port_oe = ~pair_latch_q;
	assign reset_pin_oe = wdt_reset_req | por_reset_req;

	// alternate function inputs and skip condition, registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_skip_q <= 1'b0;
			tcount_q <= 1'b0;
			ext_int_q <= 1'b0;
			analog_q <= 2'b00;
			int_prev_q <= 1'b1;
		end else begin
			bit_skip_q <= ~bit_port_pins_in[bit_test_sel];
			tcount_q <= (tp_mode_q == MIO_TP_INPUT) & nibble_port_second_in[`MIO_TP_BIT];
			ext_int_q <= int_en_q & nibble_port_second_in[`MIO_INT_BIT];
			analog_q <= pair_port_in;
			int_prev_q <= nibble_port_second_in[`MIO_INT_BIT];
		end
	end
	assign bit_test_skip = bit_skip_q;
	assign timer_count_in = tcount_q;
	assign ext_int_level = ext_int_q;
	assign analog_inputs = analog_q;
	assign int_fall = int_en_q & int_prev_q & ~nibble_port_second_in[`MIO_INT_BIT];

	// key-on wakeup detector
	assign key.lvl = pin_level;
	assign key.en = keyon_q;
	assign key.backup = ram_backup;
	mio_keyon u_keyon (
		.hclk(hclk),
		.hresetn(hresetn),
		.key(key.det)
	);
	assign wakeup_req = key.req;

	// sticky events: a set in the same cycle as its clear wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_q <= 2'b00;
		end else begin
			irq_stat_q[`MIO_IRQ_WAKE_BIT] <= key.req | (irq_stat_q[`MIO_IRQ_WAKE_BIT]
				& ~(wr_hit(`MIO_OFS_IRQ_CLR) & hwdata[`MIO_IRQ_WAKE_BIT]));
			irq_stat_q[`MIO_IRQ_INT_BIT] <= int_fall | (irq_stat_q[`MIO_IRQ_INT_BIT]
				& ~(wr_hit(`MIO_OFS_IRQ_CLR) & hwdata[`MIO_IRQ_INT_BIT]));
		end
	end
	assign irq = |(irq_stat_q & irq_en_q);

	a_bit_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_hit(`MIO_OFS_BIT_LATCH)) |=> (bit_port_pins_oe == ~$past(hwdata[3:0])))
		else $error("single-bit pin drive does not follow written latch");
	a_nibble_release: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_hit(`MIO_OFS_NIB0_LATCH) && hwdata[3:0] == 4'hF) |=> nibble_port_first_oe == 4'h0)
		else $error("first nibble pins not released after writing ones");
	a_pair_analog: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> analog_inputs == $past(pair_port_in))
		else $error("analog inputs do not follow pair pins");
	a_skip_level: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> bit_test_skip == !$past(bit_port_pins_in[bit_test_sel]))
		else $error("skip condition does not follow selected pin");
	a_reset_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		(wdt_reset_req || por_reset_req) |-> reset_pin_oe && !reset_pin_out)
		else $error("reset pin not pulled low on internal reset");
	a_timer_divide: assert property (@(posedge hclk) disable iff (!hresetn)
		(tp_mode_q == MIO_TP_T1_OUT && t1_underflow && $stable(tp_mode_q))
		|=> tp_toggle_q != $past(tp_toggle_q))
		else $error("timer pin output did not toggle on underflow");
	a_timer_readable: assert property (@(posedge hclk) disable iff (!hresetn)
		(addr_ok && !hwrite && {haddr[7:2], 2'b00} == `MIO_OFS_PIN_LEVEL
			&& tp_mode_q != MIO_TP_INPUT)
		|=> hrdata[4 + `MIO_TP_BIT] == $past(nibble_port_second_in[`MIO_TP_BIT]))
		else $error("timer pin level not visible while output selected");
	a_irq_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		(irq_stat_q[`MIO_IRQ_INT_BIT] && !(wr_hit(`MIO_OFS_IRQ_CLR) && hwdata[`MIO_IRQ_INT_BIT]))
		|=> irq_stat_q[`MIO_IRQ_INT_BIT])
		else $error("interrupt status dropped without a clear");
	a_int_clear_win: assert property (@(posedge hclk) disable iff (!hresetn)
		int_fall |=> irq_stat_q[`MIO_IRQ_INT_BIT])
		else $error("interrupt edge not recorded");
endmodule : mio_ports

// ==== verilog/mio_regs.svh ====
// register offsets, reset values and field positions of the port block
`ifndef MIO_REGS_SVH
`define MIO_REGS_SVH
`define MIO_OFS_BIT_LATCH 8'h00
`define MIO_OFS_NIB0_LATCH 8'h04
`define MIO_OFS_NIB1_LATCH 8'h08
`define MIO_OFS_PAIR_LATCH 8'h0C
`define MIO_OFS_PIN_LEVEL 8'h10
`define MIO_OFS_PULLUP 8'h14
`define MIO_OFS_KEYON 8'h18
`define MIO_OFS_CTRL 8'h1C
`define MIO_OFS_IRQ_STAT 8'h20
`define MIO_OFS_IRQ_CLR 8'h24
`define MIO_OFS_IRQ_EN 8'h28
`define MIO_RST_LATCH4 4'hF
`define MIO_RST_LATCH2 2'h3
`define MIO_RST_SEL12 12'h000
`define MIO_RST_CTRL 3'h0
`define MIO_CTRL_MODE_LSB 0
`define MIO_CTRL_INTEN_BIT 2
`define MIO_IRQ_WAKE_BIT 0
`define MIO_IRQ_INT_BIT 1
`define MIO_TP_BIT 2
`define MIO_INT_BIT 3
`endif

// ==== verilog/mio_pkg.sv ====
// types shared by the port block modules
package mio_pkg;
	typedef enum logic [1:0] {
		MIO_TP_INPUT,
		MIO_TP_T1_OUT,
		MIO_TP_T2_OUT
	} mio_tp_mode_t;
	typedef logic [11:0] mio_sel12_t;
endpackage : mio_pkg

// ==== verilog/mio_key_if.sv ====
// carrier between the port top and the key-on wakeup detector
`timescale 1ns/1ps
interface mio_key_if;
	import mio_pkg::*;
	mio_sel12_t lvl;
	mio_sel12_t en;
	logic backup;
	logic req;
	modport top (output lvl, output en, output backup, input req);
	modport det (input lvl, input en, input backup, output req);
endinterface : mio_key_if

// ==== verilog/mio_keyon.sv ====
// key-on wakeup detector for the twelve wakeup-capable pins
`timescale 1ns/1ps
module mio_keyon
	import mio_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pin levels and enables
	mio_key_if.det key
);
	logic req_q;

	// level sensitive so a key already held when back-up starts still wakes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= 1'b0;
		end else begin
			req_q <= key.backup & |(key.en & ~key.lvl);
		end
	end
	assign key.req = req_q;

	a_wake_on_low: assert property (@(posedge hclk) disable iff (!hresetn)
		(key.backup && |(key.en & ~key.lvl)) |=> key.req)
		else $error("wakeup not raised for enabled low pin");
	a_wake_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		(!key.backup || (key.en & ~key.lvl) == 12'h000) |=> !key.req)
		else $error("wakeup raised without cause");
endmodule : mio_keyon

// ==== tb/mio_pins_model.sv ====
// open-drain pads with pull-ups and outside loads for the port block
`timescale 1ns/1ps
module mio_pins_model (
	// clock
	input wire logic hclk,
	// device side
	input wire logic [13:0] oe,
	input wire logic [13:0] pu,
	// outside loads
	input wire logic [13:0] ext_low,
	input wire logic [13:0] ext_hi,
	// resolved pad levels
	output logic [13:0] lvl
);
	logic noise_q = 1'b0;
	// a floating pad must not read back a held value, so it wanders every cycle
	always @(posedge hclk) noise_q <= ~noise_q;
	// any party pulling low wins, else pull-up or a high load
	always_comb begin
		for (int i = 0; i < 14; i++) begin
			lvl[i] = (oe[i] | ext_low[i]) ? 1'b0 : ((pu[i] | ext_hi[i]) ? 1'b1 : noise_q);
		end
	end
endmodule : mio_pins_model

// ==== tb/multiplexed_io_ports_tb.sv ====
// self-checking bench for the multiplexed port block
`timescale 1ns/1ps
`include "mio_regs.svh"
module multiplexed_io_ports_tb;
	import mio_pkg::*;
	logic hclk, hresetn, hsel, hwrite, wdt_req, por_req, t1_uf, t2_uf, ram_backup, res_v;
	logic [7:0] haddr;
	logic [1:0] htrans, bsel;
	logic [2:0] hsize;
	logic [31:0] hwdata, res_d, v, el;
	logic [13:0] ext_low, ext_hi;
	wire logic hreadyout, hresp, rst_oe, skip, tcin, ext_int, wake, irq;
	wire logic [14:0] pout;
	wire logic [31:0] hrdata;
	wire logic [13:0] oe, lvl;
	wire logic [11:0] pull_up_en;
	wire logic [1:0] ain;
	int failures, num_checks, seed;
	string nm_q[$];
	logic [31:0] exp_q[$];
	mio_ports uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bit_port_pins_in(lvl[13:10]),
		.bit_port_pins_out(pout[13:10]), .bit_port_pins_oe(oe[13:10]),
		.nibble_port_first_in(lvl[3:0]),
		.nibble_port_first_out(pout[3:0]), .nibble_port_first_oe(oe[3:0]),
		.nibble_port_second_in(lvl[7:4]), .nibble_port_second_out(pout[7:4]),
		.nibble_port_second_oe(oe[7:4]), .pair_port_in(lvl[9:8]), .pair_port_out(pout[9:8]),
		.pair_port_oe(oe[9:8]), .pull_up_en(pull_up_en), .reset_pin_in(1'b1),
		.reset_pin_out(pout[14]), .reset_pin_oe(rst_oe), .wdt_reset_req(wdt_req),
		.por_reset_req(por_req), .bit_test_sel(bsel), .bit_test_skip(skip),
		.t1_underflow(t1_uf), .t2_underflow(t2_uf), .timer_count_in(tcin),
		.ext_int_level(ext_int), .analog_inputs(ain), .ram_backup(ram_backup),
		.wakeup_req(wake), .irq(irq));
	mio_pins_model pads (.hclk(hclk), .oe(oe), .pu({pull_up_en[11:10], 2'b00, pull_up_en[9:0]}),
		.ext_low(ext_low), .ext_hi(ext_hi), .lvl(lvl));
	always #5 hclk = ~hclk;
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// note the expectation, then hand the observed value to the monitor
	task automatic post(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		@(posedge hclk);
		nm_q.push_back(nm);
		exp_q.push_back(exp);
		res_d <= seen;
		res_v <= 1'b1;
		@(posedge hclk);
		res_v <= 1'b0;
	endtask : post
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
		// one more edge so the written value has reached the pins before anyone looks
		@(posedge hclk);
	endtask : wr
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		post(nm, r, exp);
	endtask : rd
	task automatic pulse(input logic t2);
		@(posedge hclk);
		t1_uf <= ~t2;
		t2_uf <= t2;
		@(posedge hclk);
		t1_uf <= 1'b0;
		t2_uf <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask : pulse
	always @(posedge hclk) begin
		if (res_v === 1'b1) begin
			check(nm_q.pop_front(), res_d, exp_q.pop_front());
		end
	end
	initial begin
		#200000;
		failures++;
		close_out();
	end
	initial begin
		{hclk, hresetn, hsel, hwrite, wdt_req, por_req, t1_uf, t2_uf, ram_backup, res_v} = '0;
		{haddr, htrans, bsel, hsize, hwdata, res_d, ext_low} = '0;
		ext_hi = 14'h0C00;
		seed = 74753;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		post("oe_reset", 32'(oe), 32'h0);
		rd("bit_latch", `MIO_OFS_BIT_LATCH, 32'hF);
		rd("nib0_latch", `MIO_OFS_NIB0_LATCH, 32'hF);
		rd("nib1_latch", `MIO_OFS_NIB1_LATCH, 32'hF);
		rd("pair_latch", `MIO_OFS_PAIR_LATCH, 32'h3);
		rd("pullup", `MIO_OFS_PULLUP, 32'h0);
		rd("unmapped", 8'h30, 32'h0);
		post("hresp", 32'(hresp), 32'h0);
		wr(`MIO_OFS_PULLUP, 32'hFFF);
		wr(`MIO_OFS_CTRL, 32'h4);
		post("pull_up_en", 32'(pull_up_en), 32'hFFF);
		for (int k = 0; k < 6; k++) begin
			v = $random(seed);
			el = $random(seed);
			wr(`MIO_OFS_BIT_LATCH, 32'(v[13:10]));
			wr(`MIO_OFS_NIB0_LATCH, 32'(v[3:0]));
			wr(`MIO_OFS_NIB1_LATCH, 32'(v[7:4]));
			wr(`MIO_OFS_PAIR_LATCH, 32'(v[9:8]));
			ext_low <= el[13:0] & v[13:0];
			post("oe", 32'(oe), 32'(v[13:0] ^ 14'h3FFF));
			post("od_out", 32'(pout), 32'h0);
			rd("pin_level", `MIO_OFS_PIN_LEVEL, 32'(v[13:0] & ~el[13:0]));
			post("analog", 32'(ain), 32'(v[9:8] & ~el[9:8]));
			post("timer_in", 32'(tcin), 32'(v[6] & ~el[6]));
			post("ext_int", 32'(ext_int), 32'(v[7] & ~el[7]));
		end
		ext_low <= '0;
		// latches back to one so every pin can be read
		wr(`MIO_OFS_BIT_LATCH, 32'hF);
		wr(`MIO_OFS_NIB0_LATCH, 32'hF);
		wr(`MIO_OFS_NIB1_LATCH, 32'hF);
		wr(`MIO_OFS_PAIR_LATCH, 32'h3);
		for (int s = 0; s < 4; s++) begin
			bsel <= s[1:0];
			ext_low <= 14'h0400 << s;
			repeat (3) @(posedge hclk);
			post("skip_low", 32'(skip), 32'h1);
			bsel <= s[1:0] ^ 2'b01;
			repeat (3) @(posedge hclk);
			post("skip_high", 32'(skip), 32'h0);
		end
		ext_low <= '0;
		wr(`MIO_OFS_CTRL, 32'h1);
		pulse(1'b0);
		post("tp_t1", 32'(oe[6]), 32'h1);
		pulse(1'b1);
		post("tp_t2_ignored", 32'(oe[6]), 32'h1);
		pulse(1'b0);
		ext_low <= 14'h0040;
		rd("tp_level", `MIO_OFS_PIN_LEVEL, 32'h3FBF);
		ext_low <= '0;
		wr(`MIO_OFS_CTRL, 32'h2);
		pulse(1'b0);
		post("tp_t1_ignored", 32'(oe[6]), 32'h0);
		pulse(1'b1);
		post("tp_t2", 32'(oe[6]), 32'h1);
		// code 3 is no output mode, so the timer pin falls back to input and is released
		wr(`MIO_OFS_CTRL, 32'h7);
		@(posedge hclk);
		post("tp_code3", 32'(oe[6]), 32'h0);
		wr(`MIO_OFS_IRQ_CLR, 32'h3);
		wr(`MIO_OFS_IRQ_EN, 32'h2);
		rd("stat_clear", `MIO_OFS_IRQ_STAT, 32'h0);
		ext_low <= 14'h0080;
		repeat (3) @(posedge hclk);
		post("irq_int", 32'(irq), 32'h1);
		rd("stat_int", `MIO_OFS_IRQ_STAT, 32'h2);
		wr(`MIO_OFS_IRQ_EN, 32'h0);
		post("irq_masked", 32'(irq), 32'h0);
		wr(`MIO_OFS_IRQ_CLR, 32'h2);
		rd("stat_cleared", `MIO_OFS_IRQ_STAT, 32'h0);
		ext_low <= '0;
		// wakeup pin keeps its pull-up on so idle reads high
		wr(`MIO_OFS_KEYON, 32'h1);
		ram_backup <= 1'b1;
		ext_low <= 14'h0002;
		repeat (3) @(posedge hclk);
		post("wake_other", 32'(wake), 32'h0);
		ext_low <= 14'h0001;
		repeat (2) @(posedge hclk);
		post("wake_pin", 32'(wake), 32'h1);
		wr(`MIO_OFS_IRQ_EN, 32'h1);
		post("irq_wake", 32'(irq), 32'h1);
		ram_backup <= 1'b0;
		ext_low <= '0;
		wdt_req <= 1'b1;
		@(posedge hclk);
		post("rst_wdt", 32'(rst_oe), 32'h1);
		wdt_req <= 1'b0;
		por_req <= 1'b1;
		@(posedge hclk);
		post("rst_por", 32'(rst_oe), 32'h1);
		por_req <= 1'b0;
		@(posedge hclk);
		post("rst_idle", 32'(rst_oe), 32'h0);
		repeat (2) @(posedge hclk);
		close_out();
	end
endmodule : multiplexed_io_ports_tb
